/* pkg/osc_cfg.svh */
// Constants for the oscillator switch and RC self-tune host controller.
// Assumes a 125 MHz hclk and a 16-bit device register port.
`ifndef OSC_CFG_SVH
`define OSC_CFG_SVH
// Host register byte offsets on the AHB-Lite side
`define OSC_OFS_CTRL 8'h00
`define OSC_OFS_TUNE 8'h04
`define OSC_OFS_STAT 8'h08
`define OSC_OFS_DEVOSC 8'h0c
`define OSC_OFS_DEVTUN 8'h10
// Device register select on the device port
`define OSC_DEV_OSCCTL 1'b0
`define OSC_DEV_TUNE 1'b1
// Byte lane enables on the device port
`define OSC_BE_HI 2'b10
`define OSC_BE_LO 2'b01
`define OSC_BE_ALL 2'b11
// Unlock keys
`define OSC_KEY_HI1 8'h78
`define OSC_KEY_HI2 8'h9a
`define OSC_KEY_LO1 8'h46
`define OSC_KEY_LO2 8'h57
// Fields of the device oscillator control register
`define OSC_NSRC_LSB 8
`define OSC_SWREQ_BIT 0
`define OSC_LOCK_BIT 5
// Fields of the device self-tune register
`define OSC_TEN_BIT 15
`define OSC_REF_BIT 12
`define OSC_LOCKST_BIT 11
`define OSC_LPOL_BIT 10
`define OSC_RANGE_BIT 9
`define OSC_RPOL_BIT 8
`define OSC_TRIM_MSB 5
// Fields of the host control and status registers
`define OSC_CTRL_GO_BIT 8
`define OSC_ST_BUSY 0
`define OSC_ST_DONE 1
`define OSC_ST_FAIL 2
`define OSC_ST_FLOCK 3
`define OSC_ST_TLOCK 4
`define OSC_ST_TRANGE 5
`define OSC_ST_TIRQ 6
`define OSC_ST_NOREF 7
// Reset values
`define OSC_RST_TUNE 16'h0000
`define OSC_RST_NSRC 3'h0
// Timing
`define OSC_CLK_NS 8
`define OSC_SETTLE_NS 100000
`define OSC_POLL_NS 8000
`define OSC_POLL_CYCLES (`OSC_POLL_NS / `OSC_CLK_NS)
`endif

/* pkg/osc_pkg.sv */
// Types shared by the oscillator host controller and its device port engine.
// Assumes the constants of osc_cfg.svh for field positions.
`default_nettype none
package osc_pkg;
  // One access on the device register port
  typedef struct packed {
    logic we;
    logic addr;
    logic [1:0] be;
    logic [15:0] wdata;
  } osc_dreq_s;
  // Sequencer states, one-hot
  typedef enum logic [11:0] {
    OSC_IDLE = 12'h001,
    OSC_RDOSC = 12'h002,
    OSC_H1 = 12'h004,
    OSC_H2 = 12'h008,
    OSC_NSRC = 12'h010,
    OSC_L1 = 12'h020,
    OSC_L2 = 12'h040,
    OSC_SWEN = 12'h080,
    OSC_SETTLE = 12'h100,
    OSC_CHECK = 12'h200,
    OSC_WTUN = 12'h400,
    OSC_RTUN = 12'h800
  } osc_state_e;
endpackage
`default_nettype wire

/* src/osc_devport.sv */
// Four-phase request/acknowledge engine for the device register port.
// Assumes ack and read data come from outside the hclk domain.
`timescale 1ns/10ps
`default_nettype none
module osc_devport (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire osc_pkg::osc_dreq_s job,
  output logic done,
  output logic [15:0] rdata,
  output logic dev_req,
  output osc_pkg::osc_dreq_s dev_cmd,
  input wire logic dev_ack,
  input wire logic [15:0] dev_rdata
);
  import osc_pkg::*;
  // Synchroniser stages; the first stages feed only the second
  logic ack_s1;
  logic ack_s2;
  logic [15:0] rd_s1;
  logic [15:0] rd_s2;
  // Waiting for ack to fall after dropping req
  logic wait_low;

  // Two-flop synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
      rd_s1 <= 16'h0000;
      rd_s2 <= 16'h0000;
    end else begin
      ack_s1 <= dev_ack;
      ack_s2 <= ack_s1;
      rd_s1 <= dev_rdata;
      rd_s2 <= rd_s1;
    end
  end

  // Handshake: req up, ack seen, req down, ack gone, done
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dev_req <= 1'b0;
      dev_cmd <= '0;
      wait_low <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (start && !dev_req && !wait_low) begin
        // Command held stable for the whole handshake
        dev_cmd <= job;
        dev_req <= 1'b1;
      end else if (dev_req && ack_s2) begin
        // Read data is stable while ack stands
        rdata <= rd_s2;
        dev_req <= 1'b0;
        wait_low <= 1'b1;
      end else if (wait_low && !ack_s2) begin
        wait_low <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* src/osc_host.sv */
// Host controller for the oscillator switch and RC self-tune registers.
// Software orders it over AHB-Lite; it drives the device register port.
// What this block does
// - Unlock high byte with 78h then 9Ah
// - Write new source right after high unlock
// - Unlock low byte with 46h then 57h
// - Set switch request right after low unlock
// - No other access inside unlock sequence
// - Wait settle delay before checking result
// - Software reads both status bits
// - Crystal reference needs crystal oscillator enabled
// - USB reference needs active device link; the block does not enforce this and only flags a missing link in status bit 7
// - Ignore polarity bits while tuning disabled
`timescale 1ns/10ps
`default_nettype none
`include "osc_cfg.svh"
module osc_host #(
  parameter int SETTLE_CYCLES = (`OSC_SETTLE_NS + `OSC_CLK_NS - 1) / `OSC_CLK_NS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic dev_req,
  output osc_pkg::osc_dreq_s dev_cmd,
  input wire logic dev_ack,
  input wire logic [15:0] dev_rdata,
  input wire logic dev_tune_irq,
  input wire logic usb_link_ok,
  output logic secondary_crystal_osc_enable
);
  import osc_pkg::*;

  // Offset match, used by read and write decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // AHB data-phase bookkeeping
  logic a_wr;
  logic [7:0] a_ofs;
  // Software-held settings
  logic [2:0] nsrc;
  logic [15:0] tune_cfg;
  // Pending orders
  logic switch_pend;
  logic tune_pend;
  // Sticky results
  logic sw_done;
  logic sw_fail;
  logic fail_lock;
  // Last words read back from the device
  logic [15:0] osc_rd;
  logic [15:0] tun_rd;
  // Sequencer
  osc_state_e state;
  osc_state_e next_state;
  logic issued;
  logic [23:0] settle_cnt;
  logic [15:0] poll_cnt;
  // Pin synchronisers; stage one feeds stage two only
  logic irq_s1;
  logic irq_s2;
  logic usb_s1;
  logic usb_s2;
  // Device port engine hookup
  logic dp_start;
  logic dp_done;
  logic [15:0] dp_rdata;
  osc_dreq_s job;

  // Bus answers: zero wait, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address-phase qualifiers
  wire addr_phase = hsel && hready && htrans[1];
  wire rd_phase = addr_phase && !hwrite;
  wire wr_ctrl = a_wr && hit(a_ofs, `OSC_OFS_CTRL);
  wire wr_tune = a_wr && hit(a_ofs, `OSC_OFS_TUNE);
  wire wr_stat = a_wr && hit(a_ofs, `OSC_OFS_STAT);
  wire go_req = wr_ctrl && hwdata[`OSC_CTRL_GO_BIT];

  // Derived tune settings
  wire t_en = tune_cfg[`OSC_TEN_BIT];
  wire t_ref_usb = tune_cfg[`OSC_REF_BIT];
  wire poll_due = (poll_cnt == 16'h0000);
  wire is_access = !(state == OSC_IDLE) && !(state == OSC_SETTLE);
  wire busy = !(state == OSC_IDLE) || switch_pend || tune_pend;

  // Status as software sees it
  logic [15:0] status;
  always_comb begin
    status = 16'h0000;
    status[`OSC_ST_BUSY] = busy;
    status[`OSC_ST_DONE] = sw_done;
    status[`OSC_ST_FAIL] = sw_fail;
    status[`OSC_ST_FLOCK] = fail_lock;
    status[`OSC_ST_TLOCK] = t_en && tun_rd[`OSC_LOCKST_BIT];
    status[`OSC_ST_TRANGE] = t_en && tun_rd[`OSC_RANGE_BIT];
    status[`OSC_ST_TIRQ] = t_en && irq_s2;
    status[`OSC_ST_NOREF] = t_en && t_ref_usb && !usb_s2;
  end

  // Read mux for the address phase
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit(haddr[7:0], `OSC_OFS_CTRL)) begin
      rd_word[2:0] = nsrc;
    end else if (hit(haddr[7:0], `OSC_OFS_TUNE)) begin
      rd_word[15:0] = tune_cfg;
    end else if (hit(haddr[7:0], `OSC_OFS_STAT)) begin
      rd_word[15:0] = status;
    end else if (hit(haddr[7:0], `OSC_OFS_DEVOSC)) begin
      rd_word[15:0] = osc_rd;
    end else if (hit(haddr[7:0], `OSC_OFS_DEVTUN)) begin
      rd_word[15:0] = tun_rd;
    end
  end

  // Capture address phase and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_wr <= 1'b0;
      a_ofs <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      a_wr <= addr_phase && hwrite;
      a_ofs <= haddr[7:0];
      if (rd_phase) begin
        hrdata <= rd_word;
      end
    end
  end

  // Software settings written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nsrc <= `OSC_RST_NSRC;
      tune_cfg <= `OSC_RST_TUNE;
    end else begin
      if (wr_ctrl) begin
        nsrc <= hwdata[2:0];
      end
      if (wr_tune) begin
        tune_cfg <= hwdata[15:0];
      end
    end
  end

  // Pending orders; a new order wins over the take
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      switch_pend <= 1'b0;
      tune_pend <= 1'b0;
    end else begin
      if (go_req) begin
        switch_pend <= 1'b1;
      end else if (state == OSC_IDLE && next_state == OSC_RDOSC) begin
        switch_pend <= 1'b0;
      end
      if (wr_tune) begin
        tune_pend <= 1'b1;
      end else if (state == OSC_IDLE && next_state == OSC_WTUN) begin
        tune_pend <= 1'b0;
      end
    end
  end

  // Sticky results: a hardware set beats a software clear
  wire chk_end = (state == OSC_CHECK) && dp_done;
  wire chk_ok = !dp_rdata[`OSC_SWREQ_BIT];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_done <= 1'b0;
      sw_fail <= 1'b0;
      fail_lock <= 1'b0;
    end else begin
      if (chk_end && chk_ok) begin
        sw_done <= 1'b1;
      end else if (wr_stat && hwdata[`OSC_ST_DONE]) begin
        sw_done <= 1'b0;
      end
      if (chk_end && !chk_ok) begin
        sw_fail <= 1'b1;
        // Lock bit tells why the switch stalled
        fail_lock <= dp_rdata[`OSC_LOCK_BIT];
      end else begin
        if (wr_stat && hwdata[`OSC_ST_FAIL]) begin
          sw_fail <= 1'b0;
        end
        if (wr_stat && hwdata[`OSC_ST_FLOCK]) begin
          fail_lock <= 1'b0;
        end
      end
    end
  end

  // Pin synchronisers for the device flag and USB link state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_s1 <= 1'b0;
      irq_s2 <= 1'b0;
      usb_s1 <= 1'b0;
      usb_s2 <= 1'b0;
    end else begin
      irq_s1 <= dev_tune_irq;
      irq_s2 <= irq_s1;
      usb_s1 <= usb_link_ok;
      usb_s2 <= usb_s1;
    end
  end

  // crystal reference needs its oscillator running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      secondary_crystal_osc_enable <= 1'b0;
    end else begin
      secondary_crystal_osc_enable <= t_en && !t_ref_usb;
    end
  end

  // Job for the current access state
  always_comb begin
    job = '0;
    job.addr = `OSC_DEV_OSCCTL;
    job.be = `OSC_BE_ALL;
    case (state)
      OSC_H1: begin
        job.we = 1'b1;
        job.be = `OSC_BE_HI;
        job.wdata = {`OSC_KEY_HI1, 8'h00};
      end
      OSC_H2: begin
        job.we = 1'b1;
        job.be = `OSC_BE_HI;
        job.wdata = {`OSC_KEY_HI2, 8'h00};
      end
      OSC_NSRC: begin
        job.we = 1'b1;
        job.be = `OSC_BE_HI;
        job.wdata = osc_rd;
        job.wdata[`OSC_NSRC_LSB +: 3] = nsrc;
      end
      OSC_L1: begin
        job.we = 1'b1;
        job.be = `OSC_BE_LO;
        job.wdata = {8'h00, `OSC_KEY_LO1};
      end
      OSC_L2: begin
        job.we = 1'b1;
        job.be = `OSC_BE_LO;
        job.wdata = {8'h00, `OSC_KEY_LO2};
      end
      OSC_SWEN: begin
        job.we = 1'b1;
        job.be = `OSC_BE_LO;
        job.wdata = osc_rd;
        job.wdata[`OSC_SWREQ_BIT] = 1'b1;
      end
      // enable, reference and polarities sent whole
      OSC_WTUN: begin
        job.we = 1'b1;
        job.addr = `OSC_DEV_TUNE;
        job.wdata = tune_cfg;
        // trim left as the device holds it while tuning
        if (t_en) begin
          job.wdata[`OSC_TRIM_MSB:0] = tun_rd[`OSC_TRIM_MSB:0];
        end
      end
      OSC_RTUN: begin
        job.addr = `OSC_DEV_TUNE;
      end
      default: begin
        job.we = 1'b0;
      end
    endcase
  end

  // One start per access state
  assign dp_start = is_access && !issued;

  // Next state; orders are only taken in idle
  always_comb begin
    next_state = state;
    case (state)
      OSC_IDLE: begin
        if (switch_pend) begin
          next_state = OSC_RDOSC;
        end else if (tune_pend) begin
          next_state = OSC_WTUN;
        end else if (poll_due) begin
          next_state = OSC_RTUN;
        end
      end
      OSC_RDOSC: if (dp_done) next_state = OSC_H1;
      OSC_H1: if (dp_done) next_state = OSC_H2;
      OSC_H2: if (dp_done) next_state = OSC_NSRC;
      OSC_NSRC: if (dp_done) next_state = OSC_L1;
      OSC_L1: if (dp_done) next_state = OSC_L2;
      OSC_L2: if (dp_done) next_state = OSC_SWEN;
      OSC_SWEN: if (dp_done) next_state = OSC_SETTLE;
      OSC_SETTLE: if (settle_cnt == 24'h000000) next_state = OSC_CHECK;
      OSC_CHECK: if (dp_done) next_state = OSC_IDLE;
      OSC_WTUN: if (dp_done) next_state = OSC_RTUN;
      OSC_RTUN: if (dp_done) next_state = OSC_IDLE;
      default: next_state = OSC_IDLE;
    endcase
  end

  // State, start flag and settle counter
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= OSC_IDLE;
      issued <= 1'b0;
      settle_cnt <= 24'h000000;
    end else begin
      state <= next_state;
      if (dp_done) begin
        issued <= 1'b0;
      end else if (dp_start) begin
        issued <= 1'b1;
      end
      if (state == OSC_SWEN && dp_done) begin
        settle_cnt <= 24'(SETTLE_CYCLES - 1);
      end else if (settle_cnt != 24'h000000) begin
        settle_cnt <= settle_cnt - 24'h000001;
      end
    end
  end

  // Poll timer and readback capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      poll_cnt <= 16'h0000;
      osc_rd <= 16'h0000;
      tun_rd <= 16'h0000;
    end else begin
      if (state == OSC_RTUN && dp_done) begin
        poll_cnt <= 16'(`OSC_POLL_CYCLES - 1);
      end else if (!poll_due) begin
        poll_cnt <= poll_cnt - 16'h0001;
      end
      if ((state == OSC_RDOSC || state == OSC_CHECK) && dp_done) begin
        osc_rd <= dp_rdata;
      end
      if (state == OSC_RTUN && dp_done) begin
        tun_rd <= dp_rdata;
      end
    end
  end

  // Device port engine
  osc_devport u_port (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(dp_start),
    .job(job),
    .done(dp_done),
    .rdata(dp_rdata),
    .dev_req(dev_req),
    .dev_cmd(dev_cmd),
    .dev_ack(dev_ack),
    .dev_rdata(dev_rdata)
  );
endmodule
`default_nettype wire

/* tb/osc_dev_model.sv */
// Behavioural device: oscillator control and self-tune words.
// Answers the four-phase port; conditions come from the bench.
`timescale 1ns/10ps
`default_nettype none
`include "osc_cfg.svh"
module osc_dev_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic dev_req,
  input wire osc_pkg::osc_dreq_s dev_cmd,
  input wire logic slow,
  input wire logic fail,
  input wire logic lock_cond,
  input wire logic range_cond,
  output logic dev_ack,
  output logic [15:0] dev_rdata,
  output logic dev_tune_irq
);
  import osc_pkg::*;
  logic [15:0] osc, tune, last_rd; // Device words and last read
  logic [1:0] hst, lst; // Unlock step of each byte
  logic [3:0] dly, swc; // Answer delay and switch time left
  wire logic [15:0] w = dev_cmd.wdata;
  wire logic en = tune[15];
  wire logic go = dev_req && !dev_ack && dly == 4'h0; // Access lands now
  function automatic logic [1:0] step(logic [1:0] s, logic [7:0] b, logic [7:0] k1,
    logic [7:0] k2);
    return (s == 2'h0 && b == k1) ? 2'h1 : (s == 2'h1 && b == k2) ? 2'h2 : 2'h0;
  endfunction
  assign dev_tune_irq = en && ((tune[10] ? lock_cond : !lock_cond)
    || (tune[8] ? range_cond : !range_cond));
  // Released bus shows the inverse, never a held word
  assign dev_rdata = dev_ack ? last_rd : ~last_rd;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {osc, tune, last_rd, hst, lst, dly, swc, dev_ack} <= '0;
    end else begin
      dly <= dev_req ? dly - {3'h0, dly != 4'h0} : {slow, 2'h0, slow};
      dev_ack <= dev_req && (dev_ack || dly == 4'h0);
      swc <= swc - {3'h0, swc != 4'h0};
      if (swc == 4'h1) begin
        osc[0] <= fail;
        osc[5] <= fail;
      end
      if (go && !dev_cmd.we) begin
        last_rd <= dev_cmd.addr ? {tune[15:12], en && lock_cond, tune[10],
          en && range_cond, tune[8:0]} : osc;
        tune[5:0] <= dev_cmd.addr && en ? tune[5:0] + 6'h01 : tune[5:0];
      end
      if (go && dev_cmd.we && dev_cmd.addr) begin
        tune <= {w[15:6], en ? tune[5:0] : w[5:0]};
      end
      if (go && dev_cmd.we && !dev_cmd.addr && dev_cmd.be == `OSC_BE_HI) begin
        hst <= step(hst, w[15:8], `OSC_KEY_HI1, `OSC_KEY_HI2);
        osc[15:8] <= hst == 2'h2 ? w[15:8] : osc[15:8];
      end
      if (go && dev_cmd.we && !dev_cmd.addr && dev_cmd.be == `OSC_BE_LO) begin
        lst <= step(lst, w[7:0], `OSC_KEY_LO1, `OSC_KEY_LO2);
        osc[7:0] <= lst == 2'h2 ? {w[7:6], 1'b0, w[4:0]} : osc[7:0];
        swc <= lst == 2'h2 && w[0] ? 4'ha : swc;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/osc_host_chk.sv */
// Checker of the host's device port order.
// Bound into osc_host; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
`include "osc_cfg.svh"
module osc_host_chk #(
  parameter int SETTLE_CYCLES = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic dev_req,
  input wire osc_pkg::osc_dreq_s dev_cmd,
  input wire logic dev_ack,
  input wire logic [15:0] dev_rdata
);
  import osc_pkg::*;
  osc_dreq_s last; // Previous request
  logic req_d; // Request one edge ago
  logic [15:0] gap; // Idle edges, saturating
  logic [15:0] trd; // Last self-tune word read
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Byte write to the oscillator word
  function automatic logic wb(osc_dreq_s c, logic [1:0] be);
    return c.we && !c.addr && c.be == be;
  endfunction
  function automatic logic bw(osc_dreq_s c, logic [1:0] be, logic [7:0] v);
    return wb(c, be) && (be[1] ? c.wdata[15:8] : c.wdata[7:0]) == v;
  endfunction
  // History of the port; saturation stops a long idle from wrapping
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {last, req_d, gap, trd} <= '0;
    end else begin
      req_d <= dev_req;
      last <= dev_req && !req_d ? dev_cmd : last;
      gap <= dev_req ? 16'h0000 : gap + {15'h0000, gap != 16'hffff};
      trd <= dev_ack && !dev_cmd.we && dev_cmd.addr ? dev_rdata : trd;
    end
  end
  sequence s_start;
    dev_req && !req_d;
  endsequence
  sequence s_after(logic [1:0] be, logic [7:0] v);
    s_start ##0 bw(last, be, v);
  endsequence
  chk_hi_key_pair: assert property (
    s_after(`OSC_BE_HI, `OSC_KEY_HI1) |-> bw(dev_cmd, `OSC_BE_HI, `OSC_KEY_HI2))
    else $error("high byte second key missing");
  chk_hi_new_source: assert property (
    s_after(`OSC_BE_HI, `OSC_KEY_HI2) |-> wb(dev_cmd, `OSC_BE_HI))
    else $error("new source write missing");
  chk_lo_key_pair: assert property (
    s_after(`OSC_BE_LO, `OSC_KEY_LO1) |-> bw(dev_cmd, `OSC_BE_LO, `OSC_KEY_LO2))
    else $error("low byte second key missing");
  chk_swreq_next: assert property (
    s_after(`OSC_BE_LO, `OSC_KEY_LO2) |-> wb(dev_cmd, `OSC_BE_LO) && dev_cmd.wdata[0])
    else $error("switch request write missing");
  chk_settle_wait: assert property (
    s_start ##0 (wb(last, `OSC_BE_LO) && last.wdata[0] && last.wdata[7:0] != `OSC_KEY_LO2)
    |-> gap >= SETTLE_CYCLES && !dev_cmd.we && dev_cmd.addr == `OSC_DEV_OSCCTL)
    else $error("result read before settle");
  chk_trim_keep: assert property (
    s_start ##0 (dev_cmd.we && dev_cmd.addr && dev_cmd.wdata[15] && trd[15])
    |-> dev_cmd.wdata[5:0] == trd[5:0]) else $error("software trim sent while tuning");
  chk_cmd_stable: assert property (dev_req && req_d |-> $stable(dev_cmd))
    else $error("command moved during request");
  chk_req_hold: assert property (dev_req && !dev_ack |=> dev_req)
    else $error("request dropped before acknowledge");
endmodule
bind osc_host osc_host_chk #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .dev_req(dev_req), .dev_cmd(dev_cmd), .dev_ack(dev_ack),
  .dev_rdata(dev_rdata));
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the oscillator host controller.
// AHB-Lite master here; the device is osc_dev_model.
`timescale 1ns/10ps
`default_nettype none
`include "osc_cfg.svh"
module tb_top;
  import osc_pkg::*;
  localparam int SETTLE = 20; // Short settle keeps the run brief
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic usb_link_ok = 1'b0;
  logic slow = 1'b0;
  logic fail = 1'b0;
  logic lock_cond = 1'b0;
  logic range_cond = 1'b0;
  wire logic hreadyout, hresp, dev_req, dev_ack, dev_tune_irq, secondary_crystal_osc_enable;
  wire logic [31:0] hrdata;
  wire logic [15:0] dev_rdata;
  wire osc_dreq_s dev_cmd;
  int errors = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h3eba9fab;
  logic [31:0] r, x;
  logic [15:0] t;
  osc_host #(.SETTLE_CYCLES(SETTLE)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .dev_req(dev_req),
    .dev_cmd(dev_cmd), .dev_ack(dev_ack), .dev_rdata(dev_rdata),
    .dev_tune_irq(dev_tune_irq), .usb_link_ok(usb_link_ok), .secondary_crystal_osc_enable(secondary_crystal_osc_enable));
  osc_dev_model u_dev (.hclk(hclk), .hresetn(hresetn), .dev_req(dev_req),
    .dev_cmd(dev_cmd), .slow(slow), .fail(fail), .lock_cond(lock_cond),
    .range_cond(range_cond), .dev_ack(dev_ack), .dev_rdata(dev_rdata),
    .dev_tune_irq(dev_tune_irq));
  initial begin
    forever #4 hclk = ~hclk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected tune status bits 7..4
  function automatic logic [31:0] exp_tstat(logic [15:0] c, logic lk, logic rg, logic usb);
    return {24'h0, c[12] && !usb, (c[10] ? lk : !lk) || (c[8] ? rg : !rg), rg, lk, 4'h0};
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One single transfer; read data lands in r
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
    chk("response", 32'(hresp), 32'h0);
  endtask
  // Bounded read loop until masked value appears
  task automatic poll(input string name, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] v);
    bus(1'b0, a, 32'h0);
    for (int n = 0; n < 400 && (r & m) !== v; n++) bus(1'b0, a, 32'h0);
    chk(name, r & m, v);
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Watchdog well beyond the roughly 6000 cycles needed
  initial begin
    repeat (40000) @(posedge hclk);
    errors++;
    results();
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, `OSC_OFS_STAT, 32'h0);
    chk("status at reset", r & 32'hfe, 32'h0);
    bus(1'b1, 8'h14, rnd());
    bus(1'b0, 8'h14, 32'h0);
    chk("unmapped read", r, 32'h0);
    $display("test reset done");
    // Alternate success and failure, random source and device speed
    for (int i = 0; i < 4; i++) begin
      x = rnd();
      fail <= i[0];
      slow <= x[3];
      bus(1'b1, `OSC_OFS_CTRL, {23'h0, 1'b1, 5'h0, x[2:0]});
      poll("switch result", `OSC_OFS_STAT, 32'he, i[0] ? 32'hc : 32'h2);
      bus(1'b0, `OSC_OFS_DEVOSC, 32'h0);
      chk("new source", 32'(r[10:8]), 32'(x[2:0]));
      chk("switch request bit", 32'(r[0]), 32'(i[0]));
      bus(1'b1, `OSC_OFS_STAT, 32'he);
      bus(1'b0, `OSC_OFS_STAT, 32'h0);
      chk("status cleared", r & 32'he, 32'h0);
    end
    $display("test switch done");
    // Every polarity pair against random conditions
    for (int i = 0; i < 4; i++) begin
      x = rnd();
      lock_cond <= x[16];
      range_cond <= x[17];
      usb_link_ok <= x[18];
      t = {1'b1, 2'b00, x[12], 1'b0, i[1], 1'b0, i[0], 2'b00, x[5:0]};
      bus(1'b1, `OSC_OFS_TUNE, {26'h0, x[5:0]});
      poll("trim while off", `OSC_OFS_DEVTUN, 32'h803f, {26'h0, x[5:0]});
      bus(1'b1, `OSC_OFS_TUNE, {16'h0, t});
      poll("tune controls", `OSC_OFS_DEVTUN, 32'h9500, {16'h0, t & 16'h9500});
      bus(1'b0, `OSC_OFS_STAT, 32'h0);
      chk("tune status", r & 32'hf0, exp_tstat(t, x[16], x[17], x[18]));
      chk("crystal enable", 32'(secondary_crystal_osc_enable), 32'(!t[12]));
      bus(1'b1, `OSC_OFS_TUNE, {16'h0, t ^ 16'h0020});
      repeat (1100) @(posedge hclk);
      bus(1'b0, `OSC_OFS_DEVTUN, 32'h0);
      chk("trim not software", 32'(r[5:0] == (t[5:0] ^ 6'h20)), 32'h0);
      chk("trim tuned", 32'(r[5:0] == t[5:0]), 32'h0);
      bus(1'b1, `OSC_OFS_TUNE, 32'h0);
      poll("tune off", `OSC_OFS_DEVTUN, 32'h8000, 32'h0);
      bus(1'b0, `OSC_OFS_STAT, 32'h0);
      chk("status masked", r & 32'hf0, 32'h0);
    end
    $display("test tune done");
    results();
  end
endmodule
`default_nettype wire
